// ---- verilog/fifo_chain_expansion.sv ----
// Chainable dual-clock FIFO stage with standard and fall-through timing
//
// Added by the designer: the address map and the AXI4-Lite register port.
`include "fifo_chain_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module fifo_chain_expansion #(
  parameter int DEPTH = `FC_NOMINAL_DEPTH,
  parameter int ADDR_W = 8
) (
  // Register bus clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Write port, on aclk
  input wire logic wr_en,
  input wire logic [`FC_PORT_W-1:0] input_data_lines,
  output logic full_indicator_n,
  output logic input_ready_flag_n,
  // Read port, on the link clock
  input wire logic link_clk,
  input wire logic rd_en,
  output logic [`FC_PORT_W-1:0] output_data_lines,
  output logic empty_indicator_n,
  output logic output_ready_flag_n,
  // Mode in force
  output fifo_chain_pkg::mode_t mode
);
  import fifo_chain_pkg::*;

  localparam int AW = $clog2(2 * DEPTH) + 1;
  localparam logic [AW-1:0] CAP_X18 = AW'(DEPTH);
  localparam logic [AW-1:0] CAP_X9 = AW'(2 * DEPTH);

  function automatic logic [AW-1:0] gray2bin(input logic [AW-1:0] g);
    logic [AW-1:0] b;
    b = '0;
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == AW - 1) ? 1'b0 : b[i + 1]);
    end
    return b;
  endfunction

  logic [`FC_PORT_W-1:0] mem_r [2 * DEPTH];

  // Read domain state that the write side watches through its synchronisers
  logic clr_s1, clr_s2, clr_ack_r;
  logic [AW-1:0] rptr_r, rgray_r, rptr_nxt, rgray_nxt;

  // Write domain state
  mode_t mode_r;
  logic clr_req_r;
  logic [AW-1:0] wptr_r, wgray_r;
  logic [AW-1:0] rgray_s1, rgray_s2;
  logic ack_s1, ack_s2;
  logic full_r;
  logic [AW-1:0] cap, rbin, wptr_nxt, level, level_nxt;
  logic push, full_nxt;

  assign cap = mode_r.both_x9 ? CAP_X9 : CAP_X18;
  assign rbin = gray2bin(rgray_s2);
  assign push = wr_en && !full_r && !clr_req_r;
  assign wptr_nxt = wptr_r + AW'(push);
  assign level = wptr_r - rbin;
  assign level_nxt = wptr_nxt - rbin;
  assign full_nxt = clr_req_r || (level_nxt >= cap);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rgray_s1 <= '0;
      rgray_s2 <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      rgray_s1 <= rgray_r;
      rgray_s2 <= rgray_s1;
      // Acknowledge leaves the link side together with the cleared read pointer
      ack_s1 <= clr_ack_r;
      ack_s2 <= ack_s1;
    end
  end

  // Write pointer, held at zero until the read side confirms its clear
  always_ff @(posedge aclk) begin
    if (!aresetn || clr_req_r) begin
      wptr_r <= '0;
      wgray_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      wgray_r <= wptr_nxt ^ (wptr_nxt >> 1);
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_r[wptr_r[AW-2:0]] <= input_data_lines & (mode_r.both_x9 ? `FC_MASK_X9 : `FC_MASK_X18);
    end
  end

  // Full is judged on the memory alone; in fall-through the output register adds one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_r <= 1'b1;
      full_indicator_n <= 1'b1;
      input_ready_flag_n <= 1'b1;
    end else begin
      full_r <= full_nxt;
      full_indicator_n <= mode_r.first_word_fallthrough || !full_nxt;
      input_ready_flag_n <= !mode_r.first_word_fallthrough || full_nxt;
    end
  end

  // Read domain state
  mode_t mode_s1, mode_s2, lmode_r;
  logic [AW-1:0] wgray_s1, wgray_s2;
  logic out_valid_r, mem_ne, pop, out_valid_nxt;

  always_ff @(posedge link_clk) begin
    clr_s1 <= clr_req_r;
    clr_s2 <= clr_s1;
    mode_s1 <= mode_r;
    mode_s2 <= mode_s1;
    wgray_s1 <= wgray_r;
    wgray_s2 <= wgray_s1;
  end

  assign mem_ne = rgray_r != wgray_s2;
  // Standard reads obey the empty flag the reader sees, never a fresher pointer
  assign pop = lmode_r.first_word_fallthrough ? (mem_ne && (!out_valid_r || rd_en)) : (rd_en && empty_indicator_n);
  assign rptr_nxt = rptr_r + AW'(pop);
  assign rgray_nxt = rptr_nxt ^ (rptr_nxt >> 1);
  assign out_valid_nxt = pop || (out_valid_r && !rd_en);

  // Mode is taken only while the clear is in force, so it is stable afterwards
  always_ff @(posedge link_clk) begin
    if (clr_s2) begin
      lmode_r <= mode_s2;
      clr_ack_r <= 1'b1;
      rptr_r <= '0;
      rgray_r <= '0;
      out_valid_r <= 1'b0;
      output_data_lines <= '0;
      empty_indicator_n <= 1'b0;
      output_ready_flag_n <= 1'b1;
    end else begin
      clr_ack_r <= 1'b0;
      rptr_r <= rptr_nxt;
      rgray_r <= rgray_nxt;
      out_valid_r <= lmode_r.first_word_fallthrough && out_valid_nxt;
      if (pop) begin
        output_data_lines <= mem_r[rptr_r[AW-2:0]];
      end
      empty_indicator_n <= lmode_r.first_word_fallthrough || (rgray_nxt != wgray_s2);
      output_ready_flag_n <= !lmode_r.first_word_fallthrough || !out_valid_nxt;
    end
  end

  // AXI4-Lite slave
  logic aw_got_r, w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write, ctrl_hit;

  assign do_write = aw_got_r && w_got_r && !bvalid;
  assign ctrl_hit = awaddr_r == ADDR_W'(`FC_CTRL_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid <= 1'b0;
      bresp <= `FC_RESP_OKAY;
    end else begin
      awready <= !aw_got_r && !(awvalid && awready) && !bvalid;
      wready <= !w_got_r && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= (ctrl_hit || awaddr_r == ADDR_W'(`FC_STAT_OFF)) ? `FC_RESP_OKAY : `FC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  // Master reset: mode latched, both pointers cleared through a four-phase handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_req_r <= 1'b1;
      mode_r <= '0;
    end else if (clr_req_r) begin
      clr_req_r <= !ack_s2;
    end else if (do_write && ctrl_hit && wstrb_r[0] && wdata_r[`FC_CTRL_MRS_BIT] && !ack_s2) begin
      clr_req_r <= 1'b1;
      mode_r.first_word_fallthrough <= wdata_r[`FC_CTRL_FIRST_WORD_FALLTHROUGH_BIT];
      mode_r.both_x9 <= wdata_r[`FC_CTRL_X9_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= '0;
    end else begin
      mode <= mode_r;
    end
  end

  logic [31:0] stat_word;
  always_comb begin
    stat_word = '0;
    stat_word[`FC_STAT_FULL_BIT] = full_r;
    stat_word[`FC_STAT_BUSY_BIT] = clr_req_r;
    stat_word[`FC_STAT_FIRST_WORD_FALLTHROUGH_BIT] = mode_r.first_word_fallthrough;
    stat_word[`FC_STAT_X9_BIT] = mode_r.both_x9;
    stat_word[`FC_STAT_LEVEL_LSB +: AW] = level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `FC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `FC_RESP_OKAY;
      if (araddr == ADDR_W'(`FC_CTRL_OFF)) begin
        rdata <= 32'({mode_r.both_x9, mode_r.first_word_fallthrough});
      end else if (araddr == ADDR_W'(`FC_STAT_OFF)) begin
        rdata <= stat_word;
      end else begin
        rdata <= '0;
        rresp <= `FC_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // Checks
  property p_std_full_at_cap;
    @(posedge aclk) disable iff (!aresetn || clr_req_r)
    (!mode_r.first_word_fallthrough && !full_indicator_n) |-> (($past(level_nxt) == cap) || $past(clr_req_r));
  endproperty
  a_std_full_at_cap: assert property (p_std_full_at_cap) else $error("standard full flag not at depth");

  property p_first_word_fallthrough_ready_below_cap;
    @(posedge aclk) disable iff (!aresetn || clr_req_r)
    (mode_r.first_word_fallthrough && !input_ready_flag_n) |-> (level < cap);
  endproperty
  a_first_word_fallthrough_ready_below_cap: assert property (p_first_word_fallthrough_ready_below_cap) else $error("input ready while memory full");

  property p_x9_upper_zero;
    @(posedge link_clk) disable iff (clr_s2)
    lmode_r.both_x9 |-> (output_data_lines[`FC_PORT_W-1:9] == '0);
  endproperty
  a_x9_upper_zero: assert property (p_x9_upper_zero) else $error("x9 output has upper bits set");

  property p_fall_through;
    @(posedge link_clk) disable iff (clr_s2)
    (lmode_r.first_word_fallthrough && !out_valid_r && mem_ne) |=> !output_ready_flag_n;
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("word did not fall through");

  property p_or_with_word;
    @(posedge link_clk) disable iff (clr_s2)
    $fell(output_ready_flag_n) |-> ($past(mem_ne) && out_valid_r);
  endproperty
  a_or_with_word: assert property (p_or_with_word) else $error("output ready without a word");

  property p_first_word_latency;
    @(posedge link_clk) disable iff (clr_s2)
    (lmode_r.first_word_fallthrough && !out_valid_r && !mem_ne && (wgray_s1 != wgray_s2)) |=> ##1 !output_ready_flag_n;
  endproperty
  a_first_word_latency: assert property (p_first_word_latency) else $error("first word latency wrong");

  property p_no_bubble;
    @(posedge link_clk) disable iff (clr_s2)
    (lmode_r.first_word_fallthrough && out_valid_r && rd_en && mem_ne) |=> !output_ready_flag_n;
  endproperty
  a_no_bubble: assert property (p_no_bubble) else $error("gap between consecutive words");

  property p_slot_frees;
    @(posedge aclk) disable iff (!aresetn || clr_req_r)
    (mode_r.first_word_fallthrough && full_r && (rgray_s1 != rgray_s2)) |=> ##1 !input_ready_flag_n;
  endproperty
  a_slot_frees: assert property (p_slot_frees) else $error("freed slot not reported");

  property p_bvalid_holds;
    @(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> (bvalid && $stable(bresp));
  endproperty
  a_bvalid_holds: assert property (p_bvalid_holds) else $error("write response dropped early");

  c_first_word: cover property (@(posedge link_clk) $fell(output_ready_flag_n));
  c_full: cover property (@(posedge aclk) $fell(input_ready_flag_n) ##[1:1000] $rose(input_ready_flag_n));
  c_mrs: cover property (@(posedge aclk) disable iff (!aresetn) $rose(clr_req_r));
  c_read: cover property (@(posedge aclk) rvalid && rready);
endmodule

`default_nettype wire

// ---- verilog/fifo_chain_regs.svh ----
// Register offsets, field positions and constants of the chainable FIFO stage
`ifndef FIFO_CHAIN_REGS_SVH
`define FIFO_CHAIN_REGS_SVH

`define FC_CTRL_OFF 8'h00
`define FC_STAT_OFF 8'h04
`define FC_CTRL_FIRST_WORD_FALLTHROUGH_BIT 0
`define FC_CTRL_X9_BIT 1
`define FC_CTRL_MRS_BIT 2
`define FC_STAT_FULL_BIT 0
`define FC_STAT_BUSY_BIT 1
`define FC_STAT_FIRST_WORD_FALLTHROUGH_BIT 2
`define FC_STAT_X9_BIT 3
`define FC_STAT_LEVEL_LSB 8
`define FC_NOMINAL_DEPTH 8192
`define FC_PORT_W 18
`define FC_MASK_X9 18'h001ff
`define FC_MASK_X18 18'h3ffff
`define FC_RESP_OKAY 2'h0
`define FC_RESP_SLVERR 2'h2
`define FC_SYNC_STAGES 2

`endif

// ---- verilog/fifo_chain_pkg.sv ----
// Types shared by the chainable FIFO stage
`default_nettype none
package fifo_chain_pkg;
  typedef struct packed {
    logic both_x9;
    logic first_word_fallthrough;
  } mode_t;
endpackage
`default_nettype wire

// ---- tb/stream_reader.sv ----
// Downstream reader model that takes words from the stage
`timescale 1ns/1ns
`default_nettype none
module stream_reader (
  // Link side
  input wire logic link_clk,
  input wire logic go,
  input wire logic stall,
  input wire logic first_word_fallthrough,
  output logic rd_en,
  input wire logic [17:0] output_data_lines,
  input wire logic empty_indicator_n,
  input wire logic output_ready_flag_n,
  // Words taken, one pulse each
  output logic got,
  output logic [17:0] got_data
);
  logic pend = 1'b0;
  initial begin
    rd_en = 1'b0;
    got = 1'b0;
    got_data = 18'h0;
  end
  // Request follows go and stall alone, not the ready flags of the stage, on its own read clock
  always @(posedge link_clk) begin
    rd_en <= go && !stall;
    // Standard reads deliver data one edge later than the request
    pend <= !first_word_fallthrough && rd_en && empty_indicator_n;
    got <= first_word_fallthrough ? (rd_en && !output_ready_flag_n) : pend;
    got_data <= output_data_lines;
  end
endmodule
`default_nettype wire

// ---- tb/fifo_chain_expansion_bench.sv ----
// Self-checking bench for the chainable FIFO stage
`include "fifo_chain_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module fifo_chain_expansion_bench;
  import fifo_chain_pkg::*;
  localparam int DEPTH = 8;
  logic aclk = 0, link_clk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, wr_en = 0, rd_en, go = 0, stall = 0, got, fw = 0, x9;
  logic [1:0] bresp, rresp, r;
  logic [17:0] din = 0, dout, got_data, mk, q[$];
  logic full_n, ir_n, empty_n, or_n;
  mode_t mode;
  int seed = 57, bad_count = 0, check_count = 0, cyc = 0, cnt, cap;

  initial forever #10 aclk = ~aclk;
  // Read clock runs freely so words fall through unasked
  initial forever begin
    #62 link_clk = 1;
    #63 link_clk = 0;
  end

  fifo_chain_expansion #(.DEPTH(DEPTH)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .wr_en(wr_en), .input_data_lines(din),
    .full_indicator_n(full_n), .input_ready_flag_n(ir_n), .link_clk(link_clk), .rd_en(rd_en),
    .output_data_lines(dout), .empty_indicator_n(empty_n), .output_ready_flag_n(or_n), .mode(mode));

  stream_reader rdr (.link_clk(link_clk), .go(go), .stall(stall), .first_word_fallthrough(fw), .rd_en(rd_en),
    .output_data_lines(dout), .empty_indicator_n(empty_n), .output_ready_flag_n(or_n), .got(got),
    .got_data(got_data));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 0; end
    join
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask

  task axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  task idle_chk;
    repeat (4) @(posedge link_clk);
    #1;
    chk({full_n, ir_n, empty_n, or_n}, fw ? 4'b1011 : 4'b1101);
  endtask

  // Model of the stage: each delivered word must be the oldest accepted one
  always @(posedge link_clk) if (got) chk(got_data, q.size() ? q.pop_front() : ~got_data);

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict;
    end
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    axr(`FC_CTRL_OFF);
    chk(d, 32'h0);
    axr(8'h0c);
    chk(r, `FC_RESP_SLVERR);
    chk(d, 32'h0);
    axw(8'h0c, 32'h3);
    chk(r, `FC_RESP_SLVERR);
    // A control write without the clear bit must leave the mode alone
    axw(`FC_CTRL_OFF, 32'h3);
    axr(`FC_CTRL_OFF);
    chk(d, 32'h0);
    for (int m = 0; m < 4; m++) begin
      fw = m[0];
      x9 = m[1];
      mk = x9 ? `FC_MASK_X9 : `FC_MASK_X18;
      cap = (x9 ? 2 * DEPTH : DEPTH) + fw;
      axw(`FC_CTRL_OFF, {29'h0, 1'b1, x9, fw});
      chk(r, `FC_RESP_OKAY);
      cnt = 0;
      do begin axr(`FC_STAT_OFF); cnt++; end while (d[`FC_STAT_BUSY_BIT] && cnt < 50);
      chk(d[3:0], {x9, fw, 2'b00});
      chk(mode, {x9, fw});
      idle_chk;
      cnt = 0;
      if (fw) begin
        @(posedge aclk);
        din <= 18'h2a5;
        wr_en <= 1;
        @(posedge aclk);
        wr_en <= 0;
        q.push_back(18'h2a5 & mk);
        while (or_n && cnt < 10) begin @(posedge link_clk); #1; cnt++; end
        chk(cnt, 3);
        chk(dout, 18'h2a5 & mk);
        cnt = 1;
      end
      // Hammer writes well past capacity; refused words are dropped
      repeat (80) begin
        @(posedge aclk);
        din <= 18'($random(seed));
        wr_en <= 1;
        @(negedge aclk);
        if (fw ? !ir_n : full_n) begin q.push_back(din & mk); cnt++; end
      end
      @(posedge aclk);
      wr_en <= 0;
      chk(cnt, cap);
      if (!fw) begin
        axr(`FC_STAT_OFF);
        chk(d[22:8], cap);
        chk(d[0], 1);
      end
      go <= 1;
      cnt = 0;
      while (q.size() && cnt < 3000) begin @(posedge aclk); stall <= 1'($random(seed)); cnt++; end
      chk(q.size(), 0);
      go <= 0;
      repeat (10) @(posedge aclk);
      idle_chk;
    end
    give_verdict;
  end
endmodule
`default_nettype wire
